//--- rtl/port2_egress_diag_defs.vh
// constants for the port 2 egress rate and cable diagnostic register bank
`ifndef PORT2_EGRESS_DIAG_DEFS_VH
`define PORT2_EGRESS_DIAG_DEFS_VH

// register indices; byte address is four times the index
`define EGRESS_RATE_IDX 16'h052A
`define CABLE_DIAG_IDX 16'h0530
`define ADDR_W 16
`define EGRESS_RATE_ADDR 16'h14A8
`define CABLE_DIAG_ADDR 16'h14C0

// egress rate register fields
`define Q1_RATE_HI 7
`define Q1_RATE_LO 4
`define Q0_RATE_HI 3
`define Q0_RATE_LO 0
`define EGRESS_RATE_RESET 8'h00

// cable diagnostic register fields
`define NEAR_SHORT_BIT 15
`define DIAG_RESULT_HI 14
`define DIAG_RESULT_LO 13
`define TEST_EN_BIT 12
`define FORCE_LINK_BIT 11
`define PWR_SAVE_DIS_BIT 10
`define REMOTE_LOOP_BIT 9
`define FAULT_CNT_HI 8
`define FAULT_CNT_LO 0

// rate codes
`define RATE_UNLIMITED 4'h0
`define RATE_FIRST_ABOVE_10M 4'h9

// shaper: 40 MHz clock, rate in kbps, 8 bits per byte credit
`define CLK_KHZ 40000
`define BYTE_THRESHOLD 20'h4E200
`define CREDIT_MAX 8'hFF
`define KBPS_W 17

`endif

//--- rtl/port2_egress_rate_cable_diag.v
// apb register bank for port 2 egress rate limiting and cable diagnostics
`timescale 1ns/100ps
// Overview of operation
// - bits 7:4 hold the priority 1 queue rate code; that queue is shaped to it.
// - bits 3:0 hold the priority 0 queue rate code; that queue is shaped to it.
// - rate codes decode to no limit or a fixed rate from 64 Kbps to 88 Mbps.
// - at 10 Mbps port speed, codes above 10 Mbps act as no limit.
// - with multiple queues disabled, only the priority 0 setting limits traffic.
// - bits 14:13 report the cable test result: normal, open, short, failed.
// - bit 15 flags a short found closer than 10 meters.
// - writing bit 12 starts the cable test; hardware clears it when done.
// - bit 10 set disables phy power saving; resets to one.
// - bit 9 set loops traffic back at this port's phy pmd/pma.
// - bits 8:0 report fault count; distance is about 0.4 m per count.
`include "port2_egress_diag_defs.vh"

module port2_egress_rate_cable_diag (
    input wire sys_clk_i,
    input wire rst_b_i,
    input wire clk_en_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [`ADDR_W-1:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire port_speed_100_i,
    input wire multi_queue_en_i,
    input wire [1:0] byte_sent_i,
    input wire link_up_i,
    input wire test_done_i,
    input wire [1:0] test_result_i,
    input wire test_near_short_i,
    input wire [8:0] test_fault_cnt_i,
    output reg [31:0] prdata_o,
    output reg pready_o,
    output reg pslverr_o,
    output reg [3:0] q1_rate_code_o,
    output reg [3:0] q0_rate_code_o,
    output reg [1:0] queue_allow_o,
    output reg cable_test_start_o,
    output reg force_link_o,
    output reg power_save_en_o,
    output reg remote_loopback_o
);

reg [7:0] egress_rate_ff;
reg test_en_ff;
reg force_link_ff;
reg pwr_save_dis_ff;
reg remote_loop_ff;
reg near_short_ff;
reg [1:0] result_ff;
reg [8:0] fault_cnt_ff;
reg [19:0] acc_ff [0:1];
reg [7:0] credit_ff [0:1];

reg [3:0] eff_code [0:1];
reg [19:0] nxt_acc [0:1];
reg [7:0] nxt_credit [0:1];
reg [31:0] nxt_prdata;
reg nxt_slverr;
reg [15:0] diag_word;
integer q;
integer k;

wire setup_phase = psel_i & ~penable_i;
wire write_commit = psel_i & penable_i & pready_o & pwrite_i;
wire hit_rate = (paddr_i == `EGRESS_RATE_ADDR);
wire hit_diag = (paddr_i == `CABLE_DIAG_ADDR);

// rate code to kbps; zero means no limit
function [`KBPS_W-1:0] code_kbps;
    input [3:0] code;
    begin
        case (code)
            4'h1: code_kbps = 17'd64;
            4'h2: code_kbps = 17'd128;
            4'h3: code_kbps = 17'd256;
            4'h4: code_kbps = 17'd512;
            4'h5: code_kbps = 17'd1000;
            4'h6: code_kbps = 17'd2000;
            4'h7: code_kbps = 17'd4000;
            4'h8: code_kbps = 17'd8000;
            4'h9: code_kbps = 17'd16000;
            4'hA: code_kbps = 17'd32000;
            4'hB: code_kbps = 17'd48000;
            4'hC: code_kbps = 17'd64000;
            4'hD: code_kbps = 17'd72000;
            4'hE: code_kbps = 17'd80000;
            4'hF: code_kbps = 17'd88000;
            default: code_kbps = 17'd0;
        endcase
    end
endfunction

// 10 Mbps port cannot honour faster limits, so they fall back to unlimited
function [3:0] speed_adjust;
    input [3:0] code;
    input fast;
    begin
        if (!fast && code >= `RATE_FIRST_ABOVE_10M) begin
            speed_adjust = `RATE_UNLIMITED;
        end else begin
            speed_adjust = code;
        end
    end
endfunction

always @* begin
    eff_code[1] = speed_adjust(egress_rate_ff[`Q1_RATE_HI:`Q1_RATE_LO], port_speed_100_i);
    eff_code[0] = speed_adjust(egress_rate_ff[`Q0_RATE_HI:`Q0_RATE_LO], port_speed_100_i);
    if (!multi_queue_en_i) begin
        eff_code[1] = `RATE_UNLIMITED;
    end
end

// credit shaper: rate in kbps added per 25 ns cycle, one byte per threshold
always @* begin
    for (q = 0; q < 2; q = q + 1) begin
        nxt_acc[q] = acc_ff[q] + {3'b000, code_kbps(eff_code[q])};
        nxt_credit[q] = credit_ff[q];
        if (eff_code[q] == `RATE_UNLIMITED) begin
            nxt_acc[q] = 20'h00000;
        end else if (nxt_acc[q] >= `BYTE_THRESHOLD) begin
            nxt_acc[q] = nxt_acc[q] - `BYTE_THRESHOLD;
            if (credit_ff[q] != `CREDIT_MAX) begin
                nxt_credit[q] = credit_ff[q] + 8'h01;
            end
        end
        // a byte sent on an empty bucket cannot go below zero
        if (byte_sent_i[q] && nxt_credit[q] != 8'h00) begin
            nxt_credit[q] = nxt_credit[q] - 8'h01;
        end
    end
end

always @* begin
    diag_word = 16'h0000;
    diag_word[`NEAR_SHORT_BIT] = near_short_ff;
    diag_word[`DIAG_RESULT_HI:`DIAG_RESULT_LO] = result_ff;
    diag_word[`TEST_EN_BIT] = test_en_ff;
    diag_word[`FORCE_LINK_BIT] = force_link_ff;
    diag_word[`PWR_SAVE_DIS_BIT] = pwr_save_dis_ff;
    diag_word[`REMOTE_LOOP_BIT] = remote_loop_ff;
    diag_word[`FAULT_CNT_HI:`FAULT_CNT_LO] = fault_cnt_ff;
    nxt_prdata = 32'h00000000;
    nxt_slverr = 1'b0;
    if (hit_rate) begin
        nxt_prdata = {24'h000000, egress_rate_ff};
    end else if (hit_diag) begin
        nxt_prdata = {16'h0000, diag_word};
    end else begin
        nxt_slverr = 1'b1;
    end
end

always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        egress_rate_ff <= `EGRESS_RATE_RESET;
        test_en_ff <= 1'b0;
        force_link_ff <= 1'b0;
        pwr_save_dis_ff <= 1'b1;
        remote_loop_ff <= 1'b0;
        near_short_ff <= 1'b0;
        result_ff <= 2'b00;
        fault_cnt_ff <= 9'h000;
        acc_ff[0] <= 20'h00000;
        acc_ff[1] <= 20'h00000;
        credit_ff[0] <= 8'h00;
        credit_ff[1] <= 8'h00;
        prdata_o <= 32'h00000000;
        pready_o <= 1'b0;
        pslverr_o <= 1'b0;
        q1_rate_code_o <= 4'h0;
        q0_rate_code_o <= 4'h0;
        queue_allow_o <= 2'b11;
        cable_test_start_o <= 1'b0;
        force_link_o <= 1'b0;
        power_save_en_o <= 1'b0;
        remote_loopback_o <= 1'b0;
    end else if (clk_en_i) begin
        // answer one cycle into the access phase, never earlier
        pready_o <= setup_phase;
        if (setup_phase) begin
            prdata_o <= pwrite_i ? 32'h00000000 : nxt_prdata;
            pslverr_o <= nxt_slverr;
        end
        if (test_done_i) begin
            test_en_ff <= 1'b0;
            result_ff <= test_result_i;
            near_short_ff <= test_near_short_i;
            fault_cnt_ff <= test_fault_cnt_i;
        end
        if (link_up_i) begin
            force_link_ff <= 1'b0;
        end
        if (write_commit && hit_rate) begin
            egress_rate_ff <= pwdata_i[`Q1_RATE_HI:`Q0_RATE_LO];
        end
        if (write_commit && hit_diag) begin
            // a fresh start wins over a completion in the same cycle
            if (pwdata_i[`TEST_EN_BIT]) begin
                test_en_ff <= 1'b1;
            end
            if (pwdata_i[`FORCE_LINK_BIT]) begin
                force_link_ff <= 1'b1;
            end
            pwr_save_dis_ff <= pwdata_i[`PWR_SAVE_DIS_BIT];
            remote_loop_ff <= pwdata_i[`REMOTE_LOOP_BIT];
        end
        for (k = 0; k < 2; k = k + 1) begin
            acc_ff[k] <= nxt_acc[k];
            credit_ff[k] <= nxt_credit[k];
            queue_allow_o[k] <= (eff_code[k] == `RATE_UNLIMITED) || (nxt_credit[k] != 8'h00);
        end
        q1_rate_code_o <= eff_code[1];
        q0_rate_code_o <= eff_code[0];
        cable_test_start_o <= test_en_ff;
        force_link_o <= force_link_ff;
        power_save_en_o <= ~pwr_save_dis_ff;
        remote_loopback_o <= remote_loop_ff;
    end
end

endmodule // port2_egress_rate_cable_diag

//--- dv/p2_monitor.sv
// assertion checker for the port 2 rate and diag bank
`timescale 1ns/100ps
`include "port2_egress_diag_defs.vh"
module p2_monitor (
    input wire sys_clk_i,
    input wire rst_b_i,
    input wire clk_en_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [`ADDR_W-1:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire port_speed_100_i,
    input wire multi_queue_en_i,
    input wire link_up_i,
    input wire test_done_i,
    input wire pready_o,
    input wire pslverr_o,
    input wire [3:0] q1_rate_code_o,
    input wire cable_test_start_o,
    input wire force_link_o,
    input wire power_save_en_o,
    input wire remote_loopback_o
);
    wire stp = psel_i & ~penable_i & clk_en_i;
    wire cm = psel_i & penable_i & pready_o & pwrite_i & clk_en_i;
    wire wd = cm & (paddr_i == `CABLE_DIAG_ADDR);
    wire wr = cm & (paddr_i == `EGRESS_RATE_ADDR);
    wire bad = (paddr_i != `CABLE_DIAG_ADDR) & (paddr_i != `EGRESS_RATE_ADDR);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    property p_rdy; stp |=> pready_o ##1 !pready_o; endproperty
    a_rdy: assert property (p_rdy) else $error("ready late");
    property p_err; stp & bad |=> pslverr_o; endproperty
    a_err: assert property (p_err) else $error("no slave error");
    property p_go; wd & pwdata_i[12] |-> ##2 cable_test_start_o; endproperty
    a_go: assert property (p_go) else $error("no start");
    property p_done; test_done_i & clk_en_i & !wd |-> ##2 !cable_test_start_o; endproperty
    a_done: assert property (p_done) else $error("start stuck");
    property p_pws; wd |-> ##2 power_save_en_o == !$past(pwdata_i[10], 2); endproperty
    a_pws: assert property (p_pws) else $error("power save");
    property p_lp; wd |-> ##2 remote_loopback_o == $past(pwdata_i[9], 2); endproperty
    a_lp: assert property (p_lp) else $error("loopback");
    property p_frc; link_up_i & clk_en_i & !wd |-> ##2 !force_link_o; endproperty
    a_frc: assert property (p_frc) else $error("force stuck");
    property p_slow;
        wr & !port_speed_100_i & (pwdata_i[7:4] >= 4'h9) ##1 !port_speed_100_i |=> q1_rate_code_o == 4'h0;
    endproperty
    a_slow: assert property (p_slow) else $error("10M override");
    property p_one; !multi_queue_en_i [*2] |-> q1_rate_code_o == 4'h0; endproperty
    a_one: assert property (p_one) else $error("single queue");
    c_done: cover property (test_done_i);
    c_err: cover property (stp & bad);
    c_frc: cover property (link_up_i & force_link_o);
endmodule // p2_monitor

bind port2_egress_rate_cable_diag p2_monitor mon (
    .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .clk_en_i(clk_en_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .port_speed_100_i(port_speed_100_i), .multi_queue_en_i(multi_queue_en_i),
    .link_up_i(link_up_i), .test_done_i(test_done_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .q1_rate_code_o(q1_rate_code_o), .cable_test_start_o(cable_test_start_o),
    .force_link_o(force_link_o), .power_save_en_o(power_save_en_o),
    .remote_loopback_o(remote_loopback_o)
);

//--- dv/tb_top.sv
// self-checking bench for the port 2 rate and diag bank
`timescale 1ns/100ps
`include "port2_egress_diag_defs.vh"
module tb_top;
    reg sys_clk_i, rst_b_i, clk_en_i, psel_i, penable_i, pwrite_i, link_up_i, test_done_i;
    reg port_speed_100_i, multi_queue_en_i, test_near_short_i;
    reg [`ADDR_W-1:0] paddr_i;
    reg [31:0] pwdata_i, r;
    reg [1:0] byte_sent_i, test_result_i;
    reg [8:0] test_fault_cnt_i;
    wire [31:0] prdata_o;
    wire pready_o, pslverr_o, cable_test_start_o, force_link_o, power_save_en_o, remote_loopback_o;
    wire [3:0] q1_rate_code_o, q0_rate_code_o;
    wire [1:0] queue_allow_o;
    integer failures = 0, n_compared = 0, i;
    port2_egress_rate_cable_diag uut (
        .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .clk_en_i(clk_en_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .port_speed_100_i(port_speed_100_i), .multi_queue_en_i(multi_queue_en_i),
        .byte_sent_i(byte_sent_i), .link_up_i(link_up_i), .test_done_i(test_done_i),
        .test_result_i(test_result_i), .test_near_short_i(test_near_short_i),
        .test_fault_cnt_i(test_fault_cnt_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .q1_rate_code_o(q1_rate_code_o), .q0_rate_code_o(q0_rate_code_o),
        .queue_allow_o(queue_allow_o), .cable_test_start_o(cable_test_start_o),
        .force_link_o(force_link_o), .power_save_en_o(power_save_en_o),
        .remote_loopback_o(remote_loopback_o)
    );
    initial begin
        sys_clk_i = 0;
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end
    task chk(input [31:0] g, input [31:0] e);
        n_compared = n_compared + 1;
        if (g !== e) begin
            failures = failures + 1;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask
    task apb(input w, input [15:0] a, input [31:0] d);
        @(posedge sys_clk_i);
        psel_i <= 1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge sys_clk_i);
        penable_i <= 1;
        do @(posedge sys_clk_i); while (pready_o !== 1'b1);
        r = prdata_o;
        psel_i <= 0;
        penable_i <= 0;
    endtask
    task rd(input [15:0] a, input [31:0] e);
        apb(0, a, 0);
        chk(r, e);
    endtask
    // outputs are registered a cycle behind the register, so let two edges pass
    task outs(input [11:0] e);
        repeat (2) @(posedge sys_clk_i);
        chk({force_link_o, cable_test_start_o, power_save_en_o, remote_loopback_o, q1_rate_code_o, q0_rate_code_o}, e);
    endtask
    task tally_and_finish;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        {rst_b_i, psel_i, penable_i, pwrite_i, link_up_i, test_done_i, test_near_short_i} = 0;
        {paddr_i, pwdata_i, byte_sent_i, test_result_i, test_fault_cnt_i} = 0;
        {clk_en_i, port_speed_100_i, multi_queue_en_i} = 3'b111;
        repeat (4) @(posedge sys_clk_i);
        rst_b_i <= 1;
        rd(`EGRESS_RATE_ADDR, 32'h0);
        rd(`CABLE_DIAG_ADDR, 32'h400);
        outs(12'h000);
        chk(queue_allow_o, 2'b11);
        // 88 Mbps on queue 0 earns its first byte credit on the fourth cycle after the write
        apb(1, `EGRESS_RATE_ADDR, 32'h0F);
        repeat (2) @(posedge sys_clk_i);
        chk(queue_allow_o, 2'b10);
        repeat (3) @(posedge sys_clk_i);
        chk(queue_allow_o, 2'b11);
        byte_sent_i <= 2'b01;
        @(posedge sys_clk_i);
        byte_sent_i <= 2'b00;
        @(posedge sys_clk_i);
        chk(queue_allow_o, 2'b10);
        apb(1, `EGRESS_RATE_ADDR, 32'hFFFF_FF51);
        rd(`EGRESS_RATE_ADDR, 32'h51);
        outs(12'h051);
        multi_queue_en_i <= 0;
        outs(12'h001);
        multi_queue_en_i <= 1;
        port_speed_100_i <= 0;
        for (i = 0; i < 16; i = i + 1) begin
            apb(1, `EGRESS_RATE_ADDR, {24'h0, i[3:0], i[3:0]});
            outs(i < 9 ? {4'h0, i[3:0], i[3:0]} : 12'h0);
        end
        port_speed_100_i <= 1;
        apb(1, `CABLE_DIAG_ADDR, 32'hFFFF_F2FF);
        rd(`CABLE_DIAG_ADDR, 32'h1200);
        outs(12'h7FF);
        test_result_i <= 2'b10;
        test_near_short_i <= 1;
        test_fault_cnt_i <= 9'h1A5;
        test_done_i <= 1;
        @(posedge sys_clk_i);
        test_done_i <= 0;
        outs(12'h3FF);
        rd(`CABLE_DIAG_ADDR, 32'hC3A5);
        apb(1, `CABLE_DIAG_ADDR, 32'h0800);
        outs(12'hAFF);
        link_up_i <= 1;
        @(posedge sys_clk_i);
        link_up_i <= 0;
        rd(`CABLE_DIAG_ADDR, 32'hC1A5);
        apb(1, 16'h14A4, 32'h11);
        chk(pslverr_o, 1);
        rd(`EGRESS_RATE_ADDR, 32'hFF);
        tally_and_finish;
    end
    initial begin
        #50000;
        failures = failures + 1;
        tally_and_finish;
    end
endmodule // tb_top
